// file: tb/mcu_instruction_execute_tb.sv
/*
  Directed testbench for the execute block: APB and issue tasks.
  Assumes a 20 MHz clock and the program memory model beside the core.
*/
`timescale 1ns/1ps
module mcu_instruction_execute_tb;
  import mcu_exec_pkg::*;
  logic sys_clk = 0, rstn = 0, issue_valid = 0, issue_ext = 0;
  op_e issue_op = idle_op;
  logic [7:0] issue_addr = '0, issue_imm = '0;
  logic [2:0] issue_bit = '0;
  logic [11:0] issue_target = '0, paddr = '0;
  logic psel = 0, penable = 0, pwrite = 0, wake_pin = 0, se;
  logic [31:0] pwdata = '0, rd, prdata;
  logic issue_ready, done, skip_taken, halted, prog_rd, pready, pslverr;
  logic [2:0] done_cycles;
  logic [11:0] program_counter, prog_addr;
  logic [15:0] prog_data;
  int err_total = 0, tests_run = 0, n;
  mcu_instruction_execute i_mcu_instruction_execute (.sys_clk, .rstn,
    .issue_valid, .issue_op, .issue_ext, .issue_addr, .issue_imm,
    .issue_bit, .issue_target, .issue_ready, .done, .done_cycles,
    .skip_taken, .halted, .program_counter, .prog_rd, .prog_addr,
    .prog_data, .wake_pin, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  prog_mem_model i_prog_mem_model (.clk(sys_clk), .rd(prog_rd),
    .addr(prog_addr), .data(prog_data));
  // 50 ns system clock
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task conclude;
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; answer taken at the rising edge that sees pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  // Offer one instruction, count edges from taking edge to done
  task issue(input op_e op, input logic e, input logic [7:0] a,
    input logic [7:0] x, input logic [11:0] t);
    issue_valid <= 1;
    issue_op <= op;
    issue_ext <= e;
    issue_addr <= a;
    issue_imm <= x;
    issue_target <= t;
    do @(negedge sys_clk); while (issue_ready !== 1'b1);
    @(posedge sys_clk) issue_valid <= 0;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (done !== 1'b1 && n < 9);
    @(posedge sys_clk);
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1;
    repeat (2) @(posedge sys_clk);
    apb(1, OFF_WORK, 32'h7f);
    apb(1, OFF_STATUS, 32'h00);
    apb(1, 12'h480, 32'h01);
    issue(add_to_work, 0, 8'h20, 8'h00, 12'h000);
    check("add cycles", n, 1);
    apb(0, OFF_WORK, 32'h0);
    check("add sum", rd, 32'h80);
    apb(0, OFF_STATUS, 32'h0);
    check("add flags", rd, 32'h0c);
    issue(and_imm, 0, 8'h00, 8'h0f, 12'h000);
    apb(0, OFF_STATUS, 32'h0);
    check("and flags", rd, 32'h0d);
    issue(clear_byte, 1, 8'h21, 8'h00, 12'h000);
    check("clear cycles", n, 2);
    issue(skip_if_zero, 1, 8'h21, 8'h00, 12'h000);
    check("skip cycles", n, 3);
    check("skip flag", skip_taken, 1);
    check("skip length", done_cycles, 3);
    issue(skip_if_nonzero, 1, 8'h21, 8'h00, 12'h000);
    check("noskip cycles", n, 2);
    apb(1, OFF_TPTR, 32'h08);
    apb(1, OFF_TPAGE, 32'h03);
    issue(table_read_page, 1, 8'h22, 8'h00, 12'h000);
    check("table cycles", n, 3);
    apb(0, 12'h488, 32'h0);
    check("table low", rd, 32'h08);
    apb(0, OFF_TFETCH, 32'h0);
    check("table high", rd, 32'hf7);
    issue(call_sub, 0, 8'h00, 8'h00, 12'h123);
    check("call cycles", n, 2);
    apb(0, OFF_PC, 32'h0);
    check("call target", rd, 32'h123);
    apb(0, OFF_SP, 32'h0);
    check("call push", rd, 32'h1);
    issue(halt_op, 0, 8'h00, 8'h00, 12'h000);
    check("halted", halted, 1);
    wake_pin <= 1;
    repeat (6) @(posedge sys_clk);
    wake_pin <= 0;
    @(negedge sys_clk);
    check("woken", halted, 0);
    @(posedge sys_clk);
    apb(0, OFF_STATUS, 32'h0);
    check("sleep flags", rd, 32'h4d);
    issue(clear_watchdog, 0, 8'h00, 8'h00, 12'h000);
    apb(0, OFF_STATUS, 32'h0);
    check("wdt clear", rd, 32'h0d);
    issue(copy_imm, 0, 8'h00, 8'h38, 12'h000);
    issue(add_imm, 0, 8'h00, 8'h29, 12'h000);
    issue(bcd_sum_fixup, 0, 8'h23, 8'h00, 12'h000);
    apb(0, 12'h48c, 32'h0);
    check("bcd fixup", rd, 32'h67);
    apb(0, OFF_STATUS, 32'h0);
    check("bcd flags", rd, 32'h04);
    apb(1, OFF_STATUS, 32'h02);
    issue(add_with_carry_to_mem, 0, 8'h20, 8'h00, 12'h000);
    apb(0, 12'h480, 32'h0);
    check("adc sum", rd, 32'h63);
    issue(skip_if_zero, 0, 8'h21, 8'h00, 12'h000);
    check("std skip cycles", n, 2);
    issue(branch_absolute, 0, 8'h00, 8'h00, 12'h2f0);
    check("jump cycles", n, 2);
    issue(copy_to_memory, 1, 8'h06, 8'h00, 12'h000);
    check("pcl cycles", n, 3);
    check("pcl write", program_counter, 12'h261);
    issue(invert_to_work, 0, 8'h22, 8'h00, 12'h000);
    apb(0, OFF_WORK, 32'h0);
    check("invert", rd, 32'hf7);
    issue(nibble_exchange_to_work, 1, 8'h22, 8'h00, 12'h000);
    check("swap cycles", n, 2);
    apb(0, OFF_WORK, 32'h0);
    check("swap", rd, 32'h80);
    issue(skip_zero_copy, 1, 8'h21, 8'h00, 12'h000);
    check("copy skip cycles", n, 3);
    apb(0, OFF_WORK, 32'h0);
    check("copy skip", rd, 32'h00);
    issue(or_imm, 0, 8'h00, 8'h5a, 12'h000);
    apb(0, OFF_WORK, 32'h0);
    check("or", rd, 32'h5a);
    issue(decrement_to_memory, 0, 8'h21, 8'h00, 12'h000);
    apb(0, 12'h484, 32'h0);
    check("decrement", rd, 32'hff);
    issue(increment_to_work, 0, 8'h21, 8'h00, 12'h000);
    apb(0, OFF_WORK, 32'h0);
    check("increment", rd, 32'h00);
    issue(idle_op, 0, 8'h00, 8'h00, 12'h000);
    check("idle cycles", n, 1);
    apb(0, 12'h300, 32'h0);
    check("unmapped", se, 1);
    conclude;
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    conclude;
  end
endmodule

// file: tb/prog_mem_model.sv
/*
  Program memory model: answers a read in the cycle after it is requested.
  Assumes the core holds the address and captures prog_data one edge later.
*/
`timescale 1ns/1ps
module prog_mem_model
(
  input wire logic clk,
  input wire logic rd,
  input wire logic [mcu_exec_pkg::PCW-1:0] addr,
  output logic [mcu_exec_pkg::PW-1:0] data
);
  logic rd_q;

  // One cycle of read latency, as the core expects
  always @(posedge clk)
    rd_q <= rd;

  // Word is the inverted low address over the low address; off a read
  // the bus shows the inverse, so no held value can be leaned on
  assign data = rd_q ? {~addr[7:0], addr[7:0]} : {addr[7:0], ~addr[7:0]};
endmodule

// file: verilog/mcu_exec_pkg.sv
/*
  Shared constants and types for the instruction execute block: widths,
  flag positions, cycle counts, register offsets and the operation codes.
  Assumes a single 20 MHz system clock and a 32-bit APB register bus.
*/
package mcu_exec_pkg;
  localparam int DW = 8;
  localparam int PCW = 12;
  localparam int PAGE_W = PCW - DW;
  localparam int PW = 16;
  localparam int DMEM_DEPTH = 256;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int AW = 12;
  localparam int WDT_PRE_W = 8;
  localparam int WDT_W = 8;

  // Flag positions inside the status byte
  localparam int FLAG_Z = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_AC = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_SC = 4;
  localparam int FLAG_CZ = 5;
  localparam int FLAG_PDF = 6;
  localparam int FLAG_TO = 7;
  localparam int SW_FLAG_TOP = 5;

  // Reset values and fixed data values
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] BYTE_FULL = 8'hff;
  localparam logic [DW-1:0] BYTE_ONE = 8'h01;
  localparam logic [PCW-1:0] PC_RESET = 12'h000;
  localparam logic [PCW-1:0] PC_STEP = 12'h001;
  localparam logic [PCW-1:0] PC_SKIP = 12'h002;
  localparam logic [SP_W-1:0] SP_STEP = 3'h1;
  localparam logic [3:0] NIB_LIMIT = 4'h9;
  localparam logic [3:0] BCD_ADJ = 4'h6;
  localparam logic [DW-1:0] PCL_ADDR = 8'h06;

  // Instruction durations in clock cycles
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;

  // APB byte offsets
  localparam logic [AW-1:0] OFF_WORK = 12'h000;
  localparam logic [AW-1:0] OFF_STATUS = 12'h004;
  localparam logic [AW-1:0] OFF_TPTR = 12'h008;
  localparam logic [AW-1:0] OFF_TFETCH = 12'h00c;
  localparam logic [AW-1:0] OFF_TPAGE = 12'h010;
  localparam logic [AW-1:0] OFF_PC = 12'h014;
  localparam logic [AW-1:0] OFF_SP = 12'h018;
  localparam logic [AW-1:0] OFF_WDT = 12'h01c;
  localparam logic [1:0] DMEM_SEL = 2'h1;

  typedef enum logic [5:0] {
    add_with_carry_to_work, add_with_carry_to_mem, add_to_work,
    add_to_memory, add_imm, and_to_work, and_to_memory, and_imm,
    or_to_work, or_to_memory, or_imm, invert_to_memory, invert_to_work,
    bcd_sum_fixup, decrement_to_memory, decrement_to_work,
    increment_to_memory, increment_to_work, copy_to_work, copy_imm,
    copy_to_memory, clear_byte, clear_bit, set_byte, set_bit,
    nibble_exchange, nibble_exchange_to_work, skip_if_zero,
    skip_zero_copy, skip_if_nonzero, skip_bit_zero, skip_bit_nonzero,
    inc_skip_zero, dec_skip_zero, inc_skip_zero_to_work,
    dec_skip_zero_to_work, table_read_page, table_read_last_page,
    preinc_table_read_page, preinc_table_read_last, call_sub,
    branch_absolute, clear_watchdog, halt_op, idle_op
  } op_e;
endpackage

// file: verilog/mcu_instruction_execute.sv
/*
  Execute stage of an 8-bit controller core: one decoded instruction per
  accepted issue, with the work register, status flags, data memory,
  program counter, call stack, table read and watchdog held here.
  Assumes the issuer waits on issue_ready, program memory answers a read
  one cycle after prog_rd, and software reaches state over APB.
*/
// Added by the designer: the address map and the APB register port.
// Notes on behaviour
// - Extended skip: three cycles when skipping, two when not.
// - Extended instruction writing program counter low takes three cycles.
// - Extended table read: three cycles, word to fetch-high and memory.
// - Skip on zero, nonzero, bit, or inc/dec result; work forms keep memory.
// - Zero test with copy moves the byte to work register too.
// - Nibble exchange; work form keeps memory, two cycles extended unless it writes counter low.
// - Add with carry: work plus byte plus carry, five flags updated.
// - Add: work plus byte or immediate, five flags updated.
// - AND with byte or immediate, only zero flag changes.
// - Call pushes counter plus one, loads target, two cycles, no flags.
// - Clear byte writes 00H; clear bit zeroes one bit; no flags.
// - Watchdog clear resets counter, expired flag and sleep flag.
// - Invert byte, zero flag only; memory or work register form.
// - BCD fixup adds 6 per nibble over 9 or carried; carry only.
// - Decrement byte, zero flag only; memory or work register form.
// - Increment byte, zero flag only; memory or work register form.
// - Halt stops, keeps state, clears watchdog, sets sleep, clears expired.
// - Jump loads target into counter, two cycles, no flags.
// - Copy byte or immediate to work, or work to byte; no flags.
// - Idle op changes nothing; counter steps to next instruction.
// - OR with byte or immediate into work, or work into byte; only zero flag changes.
// - Standard skip two cycles or one; counter low write two cycles.
`timescale 1ns/1ps
module mcu_instruction_execute
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic issue_valid,
  input wire mcu_exec_pkg::op_e issue_op,
  input wire logic issue_ext,
  input wire logic [mcu_exec_pkg::DW-1:0] issue_addr,
  input wire logic [mcu_exec_pkg::DW-1:0] issue_imm,
  input wire logic [2:0] issue_bit,
  input wire logic [mcu_exec_pkg::PCW-1:0] issue_target,
  output logic issue_ready,
  output logic done,
  output logic [2:0] done_cycles,
  output logic skip_taken,
  output logic halted,
  output logic [mcu_exec_pkg::PCW-1:0] program_counter,
  output logic prog_rd,
  output logic [mcu_exec_pkg::PCW-1:0] prog_addr,
  input wire logic [mcu_exec_pkg::PW-1:0] prog_data,
  input wire logic wake_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mcu_exec_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import mcu_exec_pkg::*;

  typedef enum logic [1:0] {st_ready, st_busy, st_halted} exec_state_e;

  logic [DW-1:0] dmem [DMEM_DEPTH];
  logic [PCW-1:0] stack [STACK_DEPTH];
  logic [SP_W-1:0] stack_ptr;
  logic [DW-1:0] work_register;
  logic [DW-1:0] flags;
  logic [DW-1:0] table_pointer_low;
  logic [DW-1:0] table_fetch_high;
  logic [PAGE_W-1:0] table_page;
  logic [WDT_PRE_W-1:0] wdt_prescale;
  logic [WDT_W-1:0] watchdog_counter;
  logic [2:0] wake_sync;
  exec_state_e state;
  logic [2:0] remain;
  logic tab_pending;
  logic [DW-1:0] tab_dest;

  logic [DW-1:0] res;
  logic wr_mem, wr_work, z_upd, arith_upd, c_only, skip, jump, push;
  logic tab, tab_inc, tab_last, wdt_clr, halt_go;
  logic [DW-1:0] next_flags;

  // Operand fetch and arithmetic datapath
  wire accept = issue_valid && issue_ready;
  wire pcl_hit = (issue_addr == PCL_ADDR);
  wire [DW-1:0] mem_rd = pcl_hit ? program_counter[DW-1:0] : dmem[issue_addr];
  wire imm_op = (issue_op == add_imm) || (issue_op == and_imm) ||
    (issue_op == or_imm) || (issue_op == copy_imm);
  wire [DW-1:0] operand = imm_op ? issue_imm : mem_rd;
  wire carry_in = ((issue_op == add_with_carry_to_work) ||
    (issue_op == add_with_carry_to_mem)) && flags[FLAG_C];
  wire [DW:0] sum9 = {1'b0, work_register} + {1'b0, operand} +
    {8'h00, carry_in};
  wire [4:0] sum_lo = {1'b0, work_register[3:0]} + {1'b0, operand[3:0]} +
    {4'h0, carry_in};
  wire ovf = (work_register[DW-1] == operand[DW-1]) &&
    (sum9[DW-1] != work_register[DW-1]);
  wire daa_lo = (work_register[3:0] > NIB_LIMIT) || flags[FLAG_AC];
  wire daa_hi = (work_register[7:4] > NIB_LIMIT) || flags[FLAG_C];
  wire [DW:0] daa9 = {1'b0, work_register} + {1'b0, daa_hi ? BCD_ADJ : 4'h0,
    daa_lo ? BCD_ADJ : 4'h0};
  wire [DW-1:0] inc_v = mem_rd + BYTE_ONE;
  wire [DW-1:0] dec_v = mem_rd - BYTE_ONE;
  wire [DW-1:0] bit_mask = BYTE_ONE << issue_bit;
  wire [DW-1:0] swapped = {mem_rd[3:0], mem_rd[7:4]};

  // Operation decode: result, destinations and side effects
  always_comb
  begin
    res = BYTE_ZERO;
    wr_mem = 1'b0;
    wr_work = 1'b0;
    z_upd = 1'b0;
    arith_upd = 1'b0;
    c_only = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    tab = 1'b0;
    tab_inc = 1'b0;
    tab_last = 1'b0;
    wdt_clr = 1'b0;
    halt_go = 1'b0;
    unique case (issue_op)
      add_with_carry_to_work, add_to_work, add_imm:
      begin
        res = sum9[DW-1:0];
        wr_work = 1'b1;
        arith_upd = 1'b1;
      end
      add_with_carry_to_mem, add_to_memory:
      begin
        res = sum9[DW-1:0];
        wr_mem = 1'b1;
        arith_upd = 1'b1;
      end
      and_to_work, and_imm, and_to_memory:
      begin
        res = work_register & operand;
        wr_work = (issue_op != and_to_memory);
        wr_mem = (issue_op == and_to_memory);
        z_upd = 1'b1;
      end
      or_to_work, or_imm, or_to_memory:
      begin
        res = work_register | operand;
        wr_work = (issue_op != or_to_memory);
        wr_mem = (issue_op == or_to_memory);
        z_upd = 1'b1;
      end
      invert_to_memory, invert_to_work:
      begin
        res = ~mem_rd;
        wr_mem = (issue_op == invert_to_memory);
        wr_work = (issue_op == invert_to_work);
        z_upd = 1'b1;
      end
      bcd_sum_fixup:
      begin
        res = daa9[DW-1:0];
        wr_mem = 1'b1;
        c_only = 1'b1;
      end
      decrement_to_memory, decrement_to_work:
      begin
        res = dec_v;
        wr_mem = (issue_op == decrement_to_memory);
        wr_work = (issue_op == decrement_to_work);
        z_upd = 1'b1;
      end
      increment_to_memory, increment_to_work:
      begin
        res = inc_v;
        wr_mem = (issue_op == increment_to_memory);
        wr_work = (issue_op == increment_to_work);
        z_upd = 1'b1;
      end
      copy_to_work, copy_imm:
      begin
        res = operand;
        wr_work = 1'b1;
      end
      copy_to_memory:
      begin
        res = work_register;
        wr_mem = 1'b1;
      end
      clear_byte, set_byte:
      begin
        res = (issue_op == set_byte) ? BYTE_FULL : BYTE_ZERO;
        wr_mem = 1'b1;
      end
      clear_bit, set_bit:
      begin
        res = (issue_op == set_bit) ? (mem_rd | bit_mask) :
          (mem_rd & ~bit_mask);
        wr_mem = 1'b1;
      end
      nibble_exchange, nibble_exchange_to_work:
      begin
        res = swapped;
        wr_mem = (issue_op == nibble_exchange);
        wr_work = (issue_op == nibble_exchange_to_work);
      end
      skip_if_zero, skip_zero_copy, skip_if_nonzero:
      begin
        res = mem_rd;
        wr_work = (issue_op == skip_zero_copy);
        skip = (issue_op == skip_if_nonzero) ? (mem_rd != BYTE_ZERO) :
          (mem_rd == BYTE_ZERO);
      end
      skip_bit_zero, skip_bit_nonzero:
      begin
        res = mem_rd;
        skip = ((mem_rd & bit_mask) == BYTE_ZERO) ==
          (issue_op == skip_bit_zero);
      end
      inc_skip_zero, inc_skip_zero_to_work:
      begin
        res = inc_v;
        wr_mem = (issue_op == inc_skip_zero);
        wr_work = (issue_op == inc_skip_zero_to_work);
        skip = (inc_v == BYTE_ZERO);
      end
      dec_skip_zero, dec_skip_zero_to_work:
      begin
        res = dec_v;
        wr_mem = (issue_op == dec_skip_zero);
        wr_work = (issue_op == dec_skip_zero_to_work);
        skip = (dec_v == BYTE_ZERO);
      end
      table_read_page, table_read_last_page, preinc_table_read_page,
      preinc_table_read_last:
      begin
        tab = 1'b1;
        tab_inc = (issue_op == preinc_table_read_page) ||
          (issue_op == preinc_table_read_last);
        tab_last = (issue_op == table_read_last_page) ||
          (issue_op == preinc_table_read_last);
      end
      call_sub:
      begin
        jump = 1'b1;
        push = 1'b1;
      end
      branch_absolute: jump = 1'b1;
      clear_watchdog: wdt_clr = 1'b1;
      halt_op: halt_go = 1'b1;
      idle_op: res = BYTE_ZERO;
    endcase
  end

  // Flag update; the counter low byte read as an operand feeds the flags like any byte
  always_comb
  begin
    next_flags = flags;
    if (z_upd || arith_upd)
      next_flags[FLAG_Z] = (res == BYTE_ZERO);
    if (arith_upd)
    begin
      next_flags[FLAG_C] = sum9[DW];
      next_flags[FLAG_AC] = sum_lo[4];
      next_flags[FLAG_OV] = ovf;
      next_flags[FLAG_SC] = ovf ^ sum9[DW-1];
    end
    if (c_only)
      next_flags[FLAG_C] = flags[FLAG_C] | daa9[DW];
    if (wdt_clr || halt_go)
      next_flags[FLAG_TO] = 1'b0;
    next_flags[FLAG_PDF] = halt_go ? 1'b1 :
      (wdt_clr ? 1'b0 : flags[FLAG_PDF]);
  end

  // Timing and program counter selection
  wire pcl_wr = wr_mem && pcl_hit;
  wire [2:0] base_cyc = tab ? (issue_ext ? CYC_THREE : CYC_TWO) :
    (jump ? CYC_TWO : (issue_ext ? CYC_TWO : CYC_ONE));
  wire [2:0] n_cyc = ((skip || pcl_wr) && !tab && !jump) ?
    base_cyc + CYC_ONE : base_cyc;
  wire [PCW-1:0] pc_inc = program_counter + PC_STEP;
  wire [PCW-1:0] next_pc = jump ? issue_target :
    (pcl_wr ? {program_counter[PCW-1:DW], res} :
    (skip ? program_counter + PC_SKIP : pc_inc));
  wire [DW-1:0] tptr_use = tab_inc ? table_pointer_low + BYTE_ONE :
    table_pointer_low;
  wire [PCW-1:0] tab_addr = tab_last ?
    {program_counter[PCW-1:DW], tptr_use} : {table_page, tptr_use};

  // Watchdog timing and wake input
  wire wdt_tick = &wdt_prescale;
  wire wdt_expire = wdt_tick && (&watchdog_counter);
  wire wdt_restart = accept && (wdt_clr || halt_go);
  wire wake_level = wake_sync[1] && wake_sync[2];

  // APB decode; a write lands at the access edge with pready high
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite && pready;
  wire mem_hit = (paddr[AW-1:AW-2] == DMEM_SEL);
  wire [DW-1:0] mem_idx = paddr[AW-3:2];
  wire reg_hit = (paddr == OFF_WORK) || (paddr == OFF_STATUS) ||
    (paddr == OFF_TPTR) || (paddr == OFF_TFETCH) || (paddr == OFF_TPAGE) ||
    (paddr == OFF_PC) || (paddr == OFF_SP) || (paddr == OFF_WDT);
  wire rd_hit = mem_hit || reg_hit;
  wire [31:0] rd_word =
    mem_hit ? {24'h000000, dmem[mem_idx]} :
    (paddr == OFF_WORK) ? {24'h000000, work_register} :
    (paddr == OFF_STATUS) ? {24'h000000, flags} :
    (paddr == OFF_TPTR) ? {24'h000000, table_pointer_low} :
    (paddr == OFF_TFETCH) ? {24'h000000, table_fetch_high} :
    (paddr == OFF_TPAGE) ? {28'h0000000, table_page} :
    (paddr == OFF_PC) ? {20'h00000, program_counter} :
    (paddr == OFF_SP) ? {29'h00000000, stack_ptr} :
    (paddr == OFF_WDT) ? {24'h000000, watchdog_counter} : 32'h00000000;

  // APB answer: one wait-free access phase after every setup
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup && !rd_hit;
      prdata <= (apb_setup && !pwrite) ? rd_word : 32'h00000000;
    end
  end

  // Data memory: core writes win over a colliding bus write
  always_ff @(posedge sys_clk)
  begin
    if (accept && wr_mem && !pcl_hit)
      dmem[issue_addr] <= res;
    else if (tab_pending)
      dmem[tab_dest] <= prog_data[DW-1:0];
    else if (apb_wr && mem_hit)
      dmem[mem_idx] <= pwdata[DW-1:0];
  end

  // Work register, flags and table registers
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      work_register <= BYTE_ZERO;
      flags <= BYTE_ZERO;
      table_pointer_low <= BYTE_ZERO;
      table_fetch_high <= BYTE_ZERO;
      table_page <= '0;
    end
    else
    begin
      if (accept && wr_work)
        work_register <= res;
      else if (apb_wr && paddr == OFF_WORK)
        work_register <= pwdata[DW-1:0];
      if (accept)
        flags <= next_flags;
      else if (apb_wr && paddr == OFF_STATUS)
        flags <= {flags[FLAG_TO:FLAG_PDF], pwdata[SW_FLAG_TOP:0]};
      if (wdt_expire)
        flags[FLAG_TO] <= 1'b1; // Expiry beats a same-cycle clear
      if (accept && tab_inc)
        table_pointer_low <= tptr_use;
      else if (apb_wr && paddr == OFF_TPTR)
        table_pointer_low <= pwdata[DW-1:0];
      if (tab_pending)
        table_fetch_high <= prog_data[PW-1:DW];
      if (apb_wr && paddr == OFF_TPAGE)
        table_page <= pwdata[PAGE_W-1:0];
    end
  end

  // Watchdog prescaler and counter, plus three-stage wake sampling
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wdt_prescale <= '0;
      watchdog_counter <= '0;
      wake_sync <= 3'h0;
    end
    else
    begin
      wake_sync <= {wake_sync[1:0], wake_pin};
      wdt_prescale <= wdt_restart ? '0 : wdt_prescale + 1'b1;
      if (wdt_restart)
        watchdog_counter <= '0;
      else if (wdt_tick)
        watchdog_counter <= watchdog_counter + 1'b1;
    end
  end

  // Call stack; wraps silently when more than eight calls nest
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      stack_ptr <= '0;
    else if (accept && push)
    begin
      stack[stack_ptr] <= pc_inc;
      stack_ptr <= stack_ptr + SP_STEP;
    end
  end

  // Sequencer: holds the issue port for the instruction's cycle count
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state <= st_ready;
      remain <= 3'h0;
      issue_ready <= 1'b0;
      done <= 1'b0;
      done_cycles <= 3'h0;
      skip_taken <= 1'b0;
      halted <= 1'b0;
      program_counter <= PC_RESET;
      prog_rd <= 1'b0;
      prog_addr <= PC_RESET;
      tab_pending <= 1'b0;
      tab_dest <= BYTE_ZERO;
    end
    else
    begin
      done <= 1'b0;
      prog_rd <= 1'b0;
      tab_pending <= prog_rd;
      unique case (state)
        st_ready:
        begin
          issue_ready <= 1'b1;
          if (accept)
          begin
            program_counter <= next_pc;
            done_cycles <= n_cyc;
            skip_taken <= skip;
            remain <= n_cyc - CYC_ONE;
            prog_rd <= tab;
            prog_addr <= tab_addr;
            tab_dest <= issue_addr;
            if (halt_go)
            begin
              state <= st_halted;
              issue_ready <= 1'b0;
              halted <= 1'b1;
              done <= 1'b1;
            end
            else if (n_cyc == CYC_ONE)
              done <= 1'b1;
            else
            begin
              state <= st_busy;
              issue_ready <= 1'b0;
            end
          end
        end
        st_busy:
        begin
          remain <= remain - CYC_ONE;
          if (remain == CYC_ONE)
          begin
            state <= st_ready;
            issue_ready <= 1'b1;
            done <= 1'b1;
          end
        end
        st_halted:
        begin
          if (wake_level || wdt_expire)
          begin
            state <= st_ready;
            halted <= 1'b0;
            issue_ready <= 1'b1;
          end
        end
        default:
        begin
          state <= st_ready;
          issue_ready <= 1'b0;
        end
      endcase
    end
  end

  // Checks on timing and side effects of accepted instructions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  wire is_skip_op = (issue_op >= skip_if_zero) &&
    (issue_op <= dec_skip_zero_to_work);

  a_ext_skip_slow: assert property (
    accept && issue_ext && is_skip_op && skip && !pcl_wr
    |=> !done [*2] ##1 done)
    else $error("extended skip did not take three cycles");
  a_ext_noskip: assert property (
    accept && issue_ext && is_skip_op && !skip && !pcl_wr
    |=> !done ##1 done)
    else $error("extended non-skip did not take two cycles");
  a_ext_pcl_write: assert property (
    accept && issue_ext && pcl_wr |=> !done [*2] ##1 done)
    else $error("extended counter low write not three cycles");
  a_table_read: assert property (
    accept && issue_ext && tab
    |=> !done [*2] ##1 (done &&
    table_fetch_high == $past(prog_data[PW-1:DW])))
    else $error("extended table read timing or data wrong");
  a_skip_advance: assert property (
    accept && skip && !pcl_wr
    |=> program_counter == $past(program_counter) + PC_SKIP)
    else $error("skip did not advance counter by two");
  a_call_push: assert property (
    accept && push |=> stack_ptr == $past(stack_ptr) + SP_STEP &&
    program_counter == $past(issue_target) && !done ##1 done)
    else $error("call did not push, load and take two cycles");
  a_wdt_clear: assert property (
    accept && wdt_clr && !wdt_expire
    |=> !flags[FLAG_TO] && !flags[FLAG_PDF] && watchdog_counter == '0)
    else $error("watchdog clear left state behind");
  a_halt_enter: assert property (
    accept && halt_go |=> halted && flags[FLAG_PDF] && !issue_ready)
    else $error("halt did not enter power down");
  a_std_skip: assert property (
    accept && !issue_ext && is_skip_op && skip && !pcl_wr
    |=> !done ##1 done)
    else $error("standard skip did not take two cycles");
  a_zero_flag: assert property (
    accept && z_upd |=> flags[FLAG_Z] == ($past(res) == BYTE_ZERO))
    else $error("zero flag does not match result");

  c_ext_skip: cover property (accept && issue_ext && is_skip_op && skip);
  c_table_ext: cover property (accept && issue_ext && tab);
  c_halt_wake: cover property (halted ##[1:40] !halted);
  c_call: cover property (accept && push);
endmodule
